// [design/pir_pkg.sv]
// Types shared by the priority resolver files
package pir_pkg;
    typedef logic [3:0] pir_lvl_type;   // Four-bit level, 0 lowest
    typedef logic [6:0] pir_vec_type;   // Vector number 0..127
    // Request offered to the core exception logic
    typedef struct packed {
        logic valid;
        pir_lvl_type level;
        pir_vec_type vector;
        logic [3:0] source;
    } pir_offer_type;
    // Offer sequencer, Gray coded along idle, offer, load
    typedef enum logic [1:0] {
        PIR_ST_IDLE = 2'b00,
        PIR_ST_OFFER = 2'b01,
        PIR_ST_LOAD = 2'b11
    } pir_state_type;
endpackage : pir_pkg

// [design/pir_regs.svh]
// Register offsets, field positions and reset values of the priority resolver
`ifndef PIR_REGS_SVH
`define PIR_REGS_SVH
// Word indices; byte address is index times four
`define PIR_IDX_PRIO_A 4'h0
`define PIR_IDX_PRIO_B 4'h1
`define PIR_IDX_VEC_WDT 4'h2
`define PIR_IDX_VEC_A 4'h3
`define PIR_IDX_VEC_B 4'h4
`define PIR_IDX_VEC_C 4'h5
`define PIR_IDX_VEC_D 4'h6
`define PIR_IDX_VEC_E 4'h7
`define PIR_IDX_VEC_F 4'h8
`define PIR_IDX_STAT 4'h9
`define PIR_IDX_CLR 4'hA
`define PIR_IDX_EN 4'hB
`define PIR_NUM_CFG 9
// Writable bits per configuration word
`define PIR_WMASK_PRIO_A 16'hFFF0
`define PIR_WMASK_PRIO_B 16'hFF00
`define PIR_WMASK_VEC_2 16'h7F7F
`define PIR_WMASK_VEC_1 16'h7F00
`define PIR_RST_CFG 16'h0000
`define PIR_RST_STAT 13'h0000
// Field positions
`define PIR_FLD_HI 15:12
`define PIR_FLD_MID 11:8
`define PIR_FLD_LO 7:4
`define PIR_VEC_HI 14:8
`define PIR_VEC_LO 6:0
`define PIR_EXT_RANGE_BIT 7
`define PIR_STAT_EXT 12
`define PIR_NUM_SRC 12
`endif

// [design/pir_resolver.sv]
// Combinational ranking of peripheral requests by level and default order
`timescale 1ns/1ps
`default_nettype none
`include "pir_regs.svh"
module pir_resolver (
    input wire logic [11:0] req, // Pending requests, index 0 ranks first
    input wire pir_pkg::pir_lvl_type lvl [12], // Programmed level per source
    input wire pir_pkg::pir_lvl_type mask, // Current core mask level
    output logic win_valid, // Some request beats the mask
    output logic [3:0] win_idx, // Winning source index
    output pir_pkg::pir_lvl_type win_level // Winning level
);
    // Plain unsigned compare: code 0 lowest, 15 highest
    function automatic logic above(input pir_pkg::pir_lvl_type a, input pir_pkg::pir_lvl_type b);
        above = a > b;
    endfunction : above

    // ========================================================
    // Ranking
    // ========================================================
    // Walk from the last source upward; a tie goes to the lower index,
    // which carries the fixed default order between and within modules
    always_comb
    begin
        win_valid = 1'b0;
        win_idx = 4'h0;
        win_level = 4'h0;
        for (int i = `PIR_NUM_SRC - 1; i >= 0; i--)
        begin
            // Level zero never beats a mask of zero or more
            if (req[i] && above(lvl[i], mask) && (!win_valid || !above(win_level, lvl[i])))
            begin
                win_valid = 1'b1;
                win_idx = 4'(i);
                win_level = lvl[i];
            end
        end
    end
endmodule : pir_resolver
`default_nettype wire

// [design/pir_top.sv]
// Peripheral interrupt priority resolver with AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pir_regs.svh"
module pir_top (
    input wire logic hclk, // System clock, 200 MHz
    input wire logic hresetn, // Power-on reset, async
    input wire logic manual_reset_n, // Manual reset pin
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size, word only
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic hreadyout, // Always ready
    output logic hresp, // Always OKAY
    output logic [31:0] hrdata, // Read data
    input wire logic [11:0] periph_req, // Peripheral request levels
    input wire pir_pkg::pir_lvl_type cur_mask, // Core mask level field now
    input wire logic cpu_ack, // Core accepts the offer
    output pir_pkg::pir_offer_type offer, // Request to the core
    output logic mask_load, // Pulse: load mask field
    output pir_pkg::pir_lvl_type mask_value, // Level to load
    input wire logic [7:0] ext_vec_in, // Externally fetched vector
    input wire logic ext_vec_strobe, // Fetched vector valid
    output pir_pkg::pir_vec_type ext_vec_out, // Fetched vector, 0..127
    output logic irq // Enabled status pending
);
    // ========================================================
    // Manual reset synchroniser
    // ========================================================
    logic mrst_s1_q;    // First stage, read only by second
    logic mrst_s2_q;    // Synchronised manual reset level
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mrst_s1_q <= 1'b0;
            mrst_s2_q <= 1'b0;
        end
        else
        begin
            mrst_s1_q <= manual_reset_n;
            mrst_s2_q <= mrst_s1_q;
        end
    end
    wire logic soft_clr = !mrst_s2_q;   // Manual reset clears the configuration words only

    // ========================================================
    // AHB-Lite slave
    // ========================================================
    logic [15:0] cfg_q [`PIR_NUM_CFG];  // Levels and vector words by index
    logic [12:0] stat_q;                // Sticky events
    logic [12:0] en_q;                  // Event enables
    logic wr_pend_q;                    // Write data phase pending
    logic [3:0] wr_idx_q;               // Index of pending write
    logic [31:0] hrdata_q;              // Read data flop
    wire logic addr_ok = hsel && hready && htrans[1];
    wire logic [3:0] addr_idx = haddr[5:2];
    wire logic addr_hit = (haddr[31:6] == 26'h000_0000) && (haddr[1:0] == 2'b00);

    // Writable bits; reserved bits never store, so they read zero
    function automatic logic [15:0] wmask(input logic [3:0] idx);
        unique case (idx)
            `PIR_IDX_PRIO_A: wmask = `PIR_WMASK_PRIO_A;
            `PIR_IDX_PRIO_B: wmask = `PIR_WMASK_PRIO_B;
            `PIR_IDX_VEC_D, `PIR_IDX_VEC_E: wmask = `PIR_WMASK_VEC_1;
            default: wmask = `PIR_WMASK_VEC_2;
        endcase
    endfunction : wmask

    // Read decode; unmapped words read zero
    function automatic logic [31:0] rd_word(input logic [3:0] idx);
        if (idx < 4'(`PIR_NUM_CFG))
            rd_word = {16'h0000, cfg_q[idx]};
        else if (idx == `PIR_IDX_STAT)
            rd_word = {19'h0_0000, stat_q};
        else if (idx == `PIR_IDX_EN)
            rd_word = {19'h0_0000, en_q};
        else
            rd_word = 32'h0000_0000;
    endfunction : rd_word

    wire logic wr_cfg = wr_pend_q && (wr_idx_q < 4'(`PIR_NUM_CFG));
    wire logic wr_clr = wr_pend_q && (wr_idx_q == `PIR_IDX_CLR);
    wire logic wr_en = wr_pend_q && (wr_idx_q == `PIR_IDX_EN);

    // Address phase capture and read data; zero wait states
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 4'h0;
            hrdata_q <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_q <= addr_ok && hwrite && addr_hit;
            wr_idx_q <= addr_idx;
            if (addr_ok && !hwrite)
                hrdata_q <= addr_hit ? rd_word(addr_idx) : 32'h0000_0000;
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // Configuration words: zero on either reset, no standby input touches them
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < `PIR_NUM_CFG; i++)
                cfg_q[i] <= `PIR_RST_CFG;
        end
        else if (soft_clr)
        begin
            for (int i = 0; i < `PIR_NUM_CFG; i++)
                cfg_q[i] <= `PIR_RST_CFG;
        end
        else if (wr_cfg)
            cfg_q[wr_idx_q] <= hwdata[15:0] & wmask(wr_idx_q);
    end

    // ========================================================
    // Level and vector fan-out
    // ========================================================
    pir_pkg::pir_lvl_type lvl [`PIR_NUM_SRC];   // Level per source
    pir_pkg::pir_vec_type vec [`PIR_NUM_SRC];   // Vector per source
    assign lvl[0] = cfg_q[`PIR_IDX_PRIO_A][`PIR_FLD_HI];
    assign lvl[1] = cfg_q[`PIR_IDX_PRIO_A][`PIR_FLD_MID];
    assign lvl[2] = cfg_q[`PIR_IDX_PRIO_A][`PIR_FLD_MID];
    assign lvl[3] = cfg_q[`PIR_IDX_PRIO_A][`PIR_FLD_LO];
    assign lvl[4] = cfg_q[`PIR_IDX_PRIO_A][`PIR_FLD_LO];
    assign lvl[5] = cfg_q[`PIR_IDX_PRIO_B][`PIR_FLD_HI];
    assign lvl[6] = cfg_q[`PIR_IDX_PRIO_B][`PIR_FLD_HI];
    assign lvl[7] = cfg_q[`PIR_IDX_PRIO_B][`PIR_FLD_HI];
    assign lvl[8] = cfg_q[`PIR_IDX_PRIO_B][`PIR_FLD_HI];
    assign lvl[9] = cfg_q[`PIR_IDX_PRIO_B][`PIR_FLD_MID];
    assign lvl[10] = cfg_q[`PIR_IDX_PRIO_B][`PIR_FLD_MID];
    assign lvl[11] = cfg_q[`PIR_IDX_PRIO_B][`PIR_FLD_MID];
    // Vectors are programmed, never fixed
    assign vec[0] = cfg_q[`PIR_IDX_VEC_E][`PIR_VEC_HI];
    assign vec[1] = cfg_q[`PIR_IDX_VEC_F][`PIR_VEC_HI];
    assign vec[2] = cfg_q[`PIR_IDX_VEC_F][`PIR_VEC_LO];
    assign vec[3] = cfg_q[`PIR_IDX_VEC_WDT][`PIR_VEC_HI];
    assign vec[4] = cfg_q[`PIR_IDX_VEC_WDT][`PIR_VEC_LO];
    assign vec[5] = cfg_q[`PIR_IDX_VEC_A][`PIR_VEC_HI];
    assign vec[6] = cfg_q[`PIR_IDX_VEC_A][`PIR_VEC_LO];
    assign vec[7] = cfg_q[`PIR_IDX_VEC_B][`PIR_VEC_HI];
    assign vec[8] = cfg_q[`PIR_IDX_VEC_B][`PIR_VEC_LO];
    assign vec[9] = cfg_q[`PIR_IDX_VEC_C][`PIR_VEC_HI];
    assign vec[10] = cfg_q[`PIR_IDX_VEC_C][`PIR_VEC_LO];
    assign vec[11] = cfg_q[`PIR_IDX_VEC_D][`PIR_VEC_HI];

    logic win_valid;                    // Winner beats mask
    logic [3:0] win_idx;                // Winner index
    pir_pkg::pir_lvl_type win_level;    // Winner level
    pir_resolver u_resolver (
        .req(periph_req),
        .lvl(lvl),
        .mask(cur_mask),
        .win_valid(win_valid),
        .win_idx(win_idx),
        .win_level(win_level)
    );

    // ========================================================
    // Offer sequencer
    // ========================================================
    pir_pkg::pir_state_type state_q;    // Sequencer state
    pir_pkg::pir_offer_type offer_q;    // Registered offer
    pir_pkg::pir_lvl_type mask_q;       // Level handed to the core
    wire logic accept = (state_q == pir_pkg::PIR_ST_OFFER) && cpu_ack;
    wire pir_pkg::pir_offer_type win_offer = {win_valid, win_level, vec[win_idx], win_idx};
    // Offer tracks the current winner; the load state gives the core one
    // cycle to update its mask before a new offer could race it
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= pir_pkg::PIR_ST_IDLE;
            offer_q <= '0;
            mask_q <= 4'h0;
        end
        else
        begin
            unique case (state_q)
                pir_pkg::PIR_ST_IDLE:
                begin
                    offer_q <= win_offer;
                    if (win_valid)
                        state_q <= pir_pkg::PIR_ST_OFFER;
                end
                pir_pkg::PIR_ST_OFFER:
                begin
                    // Accepted level goes to the core mask field
                    if (cpu_ack)
                    begin
                        mask_q <= offer_q.level;
                        offer_q <= '0;
                        state_q <= pir_pkg::PIR_ST_LOAD;
                    end
                    else
                    begin
                        offer_q <= win_offer;
                        if (!win_valid)
                            state_q <= pir_pkg::PIR_ST_IDLE;
                    end
                end
                pir_pkg::PIR_ST_LOAD:
                    state_q <= pir_pkg::PIR_ST_IDLE;
            endcase
        end
    end
    assign offer = offer_q;
    assign mask_load = (state_q == pir_pkg::PIR_ST_LOAD);
    assign mask_value = mask_q;

    // ========================================================
    // External vector and event status
    // ========================================================
    pir_pkg::pir_vec_type ext_vec_q;    // Fetched vector, range forced
    wire logic ext_bad = ext_vec_strobe && ext_vec_in[`PIR_EXT_RANGE_BIT];
    wire logic [12:0] ev_set = {ext_bad, accept ? 12'(12'h001 << offer_q.source) : 12'h000};
    // Set wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ext_vec_q <= 7'h00;
            stat_q <= `PIR_RST_STAT;
            en_q <= `PIR_RST_STAT;
        end
        else
        begin
            if (ext_vec_strobe)
                ext_vec_q <= ext_vec_in[`PIR_VEC_LO];
            stat_q <= (stat_q & ~(wr_clr ? hwdata[12:0] : 13'h0000)) | ev_set;
            if (wr_en)
                en_q <= hwdata[12:0];
        end
    end
    assign ext_vec_out = ext_vec_q;
    assign irq = |(stat_q & en_q);

    // ========================================================
    // Checks
    // ========================================================
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_div_level: assert property (win_valid && win_idx == 4'h0 |-> win_level == cfg_q[0][15:12])
        else $error("divider level not from top field");
    chk_dma_order: assert property (periph_req[1] && lvl[1] > cur_mask |-> win_idx != 4'h2)
        else $error("dma channel 1 beat channel 0");
    chk_wdt_order: assert property (periph_req[3] && lvl[3] > cur_mask |-> win_idx != 4'h4)
        else $error("refresh beat watchdog");
    chk_serial_order: assert property (periph_req[5] && lvl[5] > cur_mask && win_valid |-> !(win_idx inside {4'h6, 4'h7, 4'h8}))
        else $error("serial receive error not first");
    chk_timer_order: assert property (periph_req[9] && lvl[9] > cur_mask |-> !(win_idx inside {4'hA, 4'hB}))
        else $error("timer capture not first");
    chk_offer_above: assert property (offer_q.valid |-> offer_q.level > $past(cur_mask))
        else $error("offer not above mask");
    chk_mask_load: assert property (accept |=> mask_load && mask_value == $past(offer_q.level) ##1 !mask_load)
        else $error("mask not loaded with accepted level");
    chk_manual_clear: assert property (soft_clr |=> cfg_q[0] == 16'h0000 && cfg_q[1] == 16'h0000)
        else $error("manual reset left levels set");
    chk_reserved_zero: assert property (cfg_q[0][3:0] == 4'h0 && cfg_q[1][7:0] == 8'h00)
        else $error("reserved bits stored");
    chk_vector_src: assert property (offer_q.valid && offer_q.source == 4'h3 |-> offer_q.vector == $past(cfg_q[2][14:8]))
        else $error("watchdog vector not programmed value");
    chk_ext_range: assert property (ext_bad |=> stat_q[12] && ext_vec_out == $past(ext_vec_in[6:0]))
        else $error("external vector range not flagged");
    chk_set_wins: assert property (accept |=> stat_q[$past(offer_q.source)])
        else $error("accepted event lost");
    cov_accept: cover property (state_q == pir_pkg::PIR_ST_OFFER ##1 accept ##1 mask_load);
    cov_tie_dma: cover property (periph_req[1] && periph_req[2] && win_valid && win_idx == 4'h1);
    cov_withdraw: cover property (offer_q.valid && !cpu_ack ##1 state_q == pir_pkg::PIR_ST_IDLE);
endmodule : pir_top
`default_nettype wire

// [testbench/pir_core_model.sv]
// Behavioural model of the core exception logic facing the resolver
`timescale 1ns/1ps
`default_nettype none
module pir_core_model (
    input wire logic hclk, // System clock
    input wire logic hresetn, // Power-on reset, active low
    input wire pir_pkg::pir_offer_type offer, // Request from the resolver
    input wire logic mask_load, // Pulse: load mask field
    input wire pir_pkg::pir_lvl_type mask_value, // Level to load
    input wire logic [2:0] ack_wait, // Cycles of delay before accepting
    input wire pir_pkg::pir_lvl_type mask_force, // Mask level set by the bench
    input wire logic mask_force_en, // Apply mask_force at next edge
    output var logic cpu_ack, // Accept pulse, one cycle
    output var pir_pkg::pir_lvl_type cur_mask, // Current mask level field
    output var pir_pkg::pir_offer_type acc_last, // Last accepted offer
    output var logic [7:0] acc_count // Number of accepted offers
);
    logic [2:0] wait_q;  // Cycles the current offer has waited
    // ==========
    // Acceptance: a slow core lets the offer wait, then acks for one cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cpu_ack <= 1'b0;
            wait_q <= 3'd0;
            acc_last <= '0;
            acc_count <= 8'h00;
        end
        else
        begin
            cpu_ack <= 1'b0;
            if (!offer.valid)
                wait_q <= 3'd0;
            else if (cpu_ack)
            begin
                // The offer seen at the ack edge is the one taken
                acc_last <= offer;
                acc_count <= acc_count + 8'd1;
                wait_q <= 3'd0;
            end
            else if (wait_q >= ack_wait)
                cpu_ack <= 1'b1;
            else
                wait_q <= wait_q + 3'd1;
        end
    end
    // ==========
    // Mask field: bench override first, else loaded on accept
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cur_mask <= 4'h0;
        else if (mask_force_en)
            cur_mask <= mask_force;
        else if (mask_load)
            cur_mask <= mask_value;
    end
endmodule : pir_core_model
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking testbench for the peripheral interrupt priority resolver
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ==========
    // Signals
    logic hclk = 1'b0; // 200 MHz clock
    logic hresetn = 1'b0; // Power-on reset
    logic manual_reset_n = 1'b1; // Manual reset pin
    logic hsel = 1'b0; // Bus select
    logic [31:0] haddr = 32'h0000_0000; // Bus address
    logic [1:0] htrans = 2'b00; // Transfer type
    logic hwrite = 1'b0; // Write flag
    logic [2:0] hsize = 3'b010; // Word transfers only
    logic [31:0] hwdata = 32'h0000_0000; // Write data
    logic hreadyout; // Slave ready, also the bus ready
    logic hresp; // Response
    logic [31:0] hrdata; // Read data
    logic [11:0] periph_req = 12'h000; // Peripheral requests
    pir_pkg::pir_lvl_type cur_mask; // Core mask level
    logic cpu_ack; // Core accept
    pir_pkg::pir_offer_type offer; // Offer to the core
    logic mask_load; // Mask load pulse
    pir_pkg::pir_lvl_type mask_value; // Level to load
    logic [7:0] ext_vec_in = 8'h00; // Fetched vector
    logic ext_vec_strobe = 1'b0; // Fetched vector strobe
    pir_pkg::pir_vec_type ext_vec_out; // Fetched vector out
    logic irq; // Interrupt line
    logic [2:0] ack_wait = 3'd0; // Core response delay
    logic [3:0] mask_force = 4'h0; // Mask value to impose
    logic mask_force_en = 1'b0; // Impose mask
    pir_pkg::pir_offer_type acc_last; // Last accepted offer
    logic [7:0] acc_count; // Accepted offers
    int mismatches = 0; // Failed comparisons
    int checks = 0; // Comparisons made
    int cycles = 0; // Timeout counter
    logic [31:0] rd; // Read result
    logic got; // An offer was accepted
    // Programmed levels with first word 3570 and second 9B00
    logic [3:0] lvl_of [12] = '{4'd3, 4'd5, 4'd5, 4'd7, 4'd7, 4'd9, 4'd9, 4'd9, 4'd9,
                                4'd11, 4'd11, 4'd11};
    // Sources in the upper and lower halves of vector words 2..8
    int hi_s [7] = '{3, 5, 7, 9, 11, 0, 1};
    int lo_s [7] = '{4, 6, 8, 10, -1, -1, 2};
    // Tie cases at one level: request set and expected winner
    logic [11:0] tie_req [8] = '{12'hFFF, 12'h006, 12'h018, 12'h1E0, 12'h1C0, 12'h180,
                                 12'hE00, 12'hC00};
    logic [3:0] tie_src [8] = '{4'd0, 4'd1, 4'd3, 4'd5, 4'd6, 4'd7, 4'd9, 4'd10};
    always #2.5 hclk = ~hclk;
    // ==========
    // Design and far-side model
    pir_top uut (.hclk(hclk), .hresetn(hresetn), .manual_reset_n(manual_reset_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .periph_req(periph_req), .cur_mask(cur_mask), .cpu_ack(cpu_ack),
        .offer(offer), .mask_load(mask_load), .mask_value(mask_value),
        .ext_vec_in(ext_vec_in), .ext_vec_strobe(ext_vec_strobe),
        .ext_vec_out(ext_vec_out), .irq(irq));
    pir_core_model core (.hclk(hclk), .hresetn(hresetn), .offer(offer),
        .mask_load(mask_load), .mask_value(mask_value), .ack_wait(ack_wait),
        .mask_force(mask_force), .mask_force_en(mask_force_en), .cpu_ack(cpu_ack),
        .cur_mask(cur_mask), .acc_last(acc_last), .acc_count(acc_count));
    // ==========
    // Checking and closing
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test
    // Cut a hang short; the whole run needs well under this
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            finish_test();
        end
    end
    // ==========
    // Bus tasks: hold each phase until ready is sampled high
    task automatic wait_ready;
        do @(posedge hclk);
        while (hreadyout !== 1'b1);
    endtask : wait_ready
    task automatic ahb_access(input logic wr, input logic [31:0] a, input logic [31:0] d,
                              output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        r = hrdata;
    endtask : ahb_access
    task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] unused;
        ahb_access(1'b1, a, d, unused);
    endtask : ahb_write
    task automatic ahb_read(input logic [31:0] a, output logic [31:0] r);
        ahb_access(1'b0, a, 32'h0000_0000, r);
    endtask : ahb_read
    // ==========
    // Core-side tasks
    function automatic logic [6:0] vec_of(input int i);
        return 7'h70 + 7'(i);
    endfunction : vec_of
    // Present requests with a given mask; the window is long for a slow core
    task automatic offer_run(input logic [11:0] r, input logic [3:0] m, output logic acc);
        logic [7:0] n0;
        n0 = acc_count;
        @(posedge hclk);
        mask_force <= m;
        mask_force_en <= 1'b1;
        periph_req <= r;
        @(posedge hclk);
        mask_force_en <= 1'b0;
        repeat (14) @(posedge hclk);
        acc = (acc_count !== n0);
        periph_req <= 12'h000;
        repeat (3) @(posedge hclk);
    endtask : offer_run
    task automatic expect_win(input logic [11:0] r, input logic [3:0] src,
                              input logic [3:0] lvl);
        offer_run(r, 4'h0, got);
        chk(got, 1'b1, "accepted");
        chk(acc_last.source, src, "winner");
        chk(acc_last.level, lvl, "level");
        chk(acc_last.vector, vec_of(src), "vector");
        chk(cur_mask, lvl, "mask");
    endtask : expect_win
    task automatic ext_vec(input logic [7:0] v, input logic [6:0] exp);
        @(posedge hclk);
        ext_vec_in <= v;
        ext_vec_strobe <= 1'b1;
        @(posedge hclk);
        ext_vec_strobe <= 1'b0;
        @(posedge hclk);
        chk(ext_vec_out, exp, "ext vector");
    endtask : ext_vec
    // ==========
    // Main sequence
    initial
    begin
        logic [15:0] w;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        // Config words stay cleared two edges while the manual reset syncs
        repeat (4) @(posedge hclk);
        ahb_read(32'h0000_0000, rd);
        chk(rd, 32'h0000_0000, "level a reset");
        ahb_read(32'h0000_0004, rd);
        chk(rd, 32'h0000_0000, "level b reset");
        ahb_read(32'h0000_0024, rd);
        chk(rd, 32'h0000_0000, "status reset");
        chk(hresp, 1'b0, "response okay");
        // Reserved bits read zero; unmapped reads zero
        ahb_write(32'h0000_0000, 32'h0000_FFFF);
        ahb_read(32'h0000_0000, rd);
        chk(rd, 32'h0000_FFF0, "level a mask");
        ahb_write(32'h0000_0004, 32'h0000_FFFF);
        ahb_read(32'h0000_0004, rd);
        chk(rd, 32'h0000_FF00, "level b mask");
        ahb_write(32'h0000_0018, 32'h0000_FFFF);
        ahb_read(32'h0000_0018, rd);
        chk(rd, 32'h0000_7F00, "vector mask");
        ahb_write(32'h0000_0040, 32'h0000_FFFF);
        ahb_read(32'h0000_0040, rd);
        chk(rd, 32'h0000_0000, "unmapped");
        // Distinct vector per source
        for (int k = 0; k < 7; k++)
        begin
            w = {1'b0, vec_of(hi_s[k]), 1'b0, (lo_s[k] < 0) ? 7'h00 : vec_of(lo_s[k])};
            ahb_write(32'(k * 4 + 8), {16'h0000, w});
            ahb_read(32'(k * 4 + 8), rd);
            chk(rd, {16'h0000, w}, "vector word");
        end
        // Each source alone at its field's level
        ahb_write(32'h0000_0000, 32'h0000_3570);
        ahb_write(32'h0000_0004, 32'h0000_9B00);
        for (int i = 0; i < 12; i++)
            expect_win(12'(1 << i), 4'(i), lvl_of[i]);
        // Higher code wins across units, with a slow core
        ack_wait <= 3'd3;
        expect_win(12'hFFF, 4'd9, 4'd11);
        expect_win(12'h007, 4'd1, 4'd5);
        // Sticky status, enable and clear
        ahb_read(32'h0000_0024, rd);
        chk(rd, 32'h0000_0FFF, "status");
        chk(irq, 1'b0, "irq masked");
        ahb_write(32'h0000_002C, 32'h0000_0008);
        ahb_read(32'h0000_002C, rd);
        chk(rd, 32'h0000_0008, "enable");
        chk(irq, 1'b1, "irq raised");
        ahb_write(32'h0000_0028, 32'h0000_0008);
        ahb_read(32'h0000_0024, rd);
        chk(rd, 32'h0000_0FF7, "status cleared");
        chk(irq, 1'b0, "irq cleared");
        // Ties at one level follow the fixed order
        ahb_write(32'h0000_0000, 32'h0000_4440);
        ahb_write(32'h0000_0004, 32'h0000_4400);
        for (int t = 0; t < 8; t++)
            expect_win(tie_req[t], tie_src[t], 4'd4);
        // Level must exceed the mask; level zero never offered
        offer_run(12'h001, 4'h4, got);
        chk(got, 1'b0, "equal to mask");
        offer_run(12'h001, 4'h3, got);
        chk(got, 1'b1, "above mask");
        ahb_write(32'h0000_0000, 32'h0000_0440);
        offer_run(12'h001, 4'h0, got);
        chk(got, 1'b0, "level zero");
        // Fetched vectors: out of range flagged, low bits kept
        ext_vec(8'h85, 7'h05);
        ext_vec(8'h7F, 7'h7F);
        ahb_read(32'h0000_0024, rd);
        chk(rd[12], 1'b1, "range flag");
        ahb_write(32'h0000_0028, 32'h0000_1FFF);
        ahb_read(32'h0000_0024, rd);
        chk(rd, 32'h0000_0000, "status all clear");
        // Manual reset clears configuration, enable survives
        manual_reset_n <= 1'b0;
        repeat (4) @(posedge hclk);
        manual_reset_n <= 1'b1;
        repeat (4) @(posedge hclk);
        ahb_read(32'h0000_0004, rd);
        chk(rd, 32'h0000_0000, "level b manual");
        ahb_read(32'h0000_001C, rd);
        chk(rd, 32'h0000_0000, "vector manual");
        ahb_read(32'h0000_002C, rd);
        chk(rd, 32'h0000_0008, "enable kept");
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
